// *** ccb_exec.sv ***
// Purpose: decode and execute clear, compare, complement and decimal adjust
// Assumes: fetch stage and operand ports are on pclk; apb slave with no wait state
// Notes: one instruction per cycle; results land one edge after ins.valid
//
// Chosen here: register access over APB and the register offsets.
module ccb_exec
	import ccb_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire ccb_ins_type ins,
	input wire ccb_opnd_type opnd,
	output ccb_res_type res,
	output logic [7:0] acc,
	output logic [4:0] flags
);
	logic src_mode_ff;
	logic [7:0] acc_ff;
	logic [4:0] flg_ff;
	ccb_res_type res_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [7:0] nxt_acc;
	logic [4:0] nxt_flg;
	ccb_res_type nxt_res;

	// ---- apb decode ----
	wire logic setup_ph = psel & ~penable;
	wire logic access_ph = psel & penable & pready_ff;
	wire logic hit_ctrl = (paddr == OFS_CTRL);
	wire logic hit_acc = (paddr == OFS_ACC);
	wire logic hit_flg = (paddr == OFS_FLAGS);
	wire logic hit_stat = (paddr == OFS_STAT);
	wire logic hit_any = hit_ctrl | hit_acc | hit_flg | hit_stat;
	wire logic wr_acc = access_ph & pwrite & hit_acc;
	wire logic wr_flg = access_ph & pwrite & hit_flg;
	wire logic wr_ctrl = access_ph & pwrite & hit_ctrl;
	wire logic [31:0] rd_mux =
		hit_ctrl ? {31'h0, src_mode_ff} :
		hit_acc ? {24'h0, acc_ff} :
		hit_flg ? {27'h0, flg_ff} :
		hit_stat ? {24'h0, res_ff.illegal, res_ff.bit_we, res_ff.done, 1'b0, res_ff.states} :
		32'h0;

	// ---- opcode selection ----
	wire logic esc = (ins.b0 == ESC_BYTE);
	// binary mode: extended forms only behind the escape byte
	wire logic ext_ok = src_mode_ff ? ~esc : esc;
	wire logic [7:0] xop = src_mode_ff ? ins.b0 : ins.b1;
	wire logic [7:0] xsub = src_mode_ff ? ins.b1 : ins.b2;
	// short forms never look at the mode or a prefix
	wire logic [7:0] lop = ins.b0;
	wire logic [3:0] bin_add = src_mode_ff ? 4'h0 : BIN_EXTRA;
	wire logic [3:0] port_bit_add = opnd.on_port ? PORT_BIT_EXTRA : 4'h0;
	wire logic [3:0] port_dir_add = opnd.on_port ? PORT_DIR_EXTRA : 4'h0;

	// compare datapath
	wire logic [8:0] d8 = {1'b0, opnd.dst[7:0]} - {1'b0, opnd.src[7:0]};
	wire logic [16:0] d16 = {1'b0, opnd.dst[15:0]} - {1'b0, opnd.src[15:0]};
	wire logic [32:0] d32 = {1'b0, opnd.dst} - {1'b0, opnd.src};
	wire logic [4:0] dnib = {1'b0, opnd.dst[3:0]} - {1'b0, opnd.src[3:0]};
	wire logic v8 = (opnd.dst[7] ^ opnd.src[7]) & (d8[7] ^ opnd.dst[7]);
	wire logic v16 = (opnd.dst[15] ^ opnd.src[15]) & (d16[15] ^ opnd.dst[15]);
	wire logic v32 = (opnd.dst[31] ^ opnd.src[31]) & (d32[31] ^ opnd.dst[31]);

	// decimal adjust datapath
	wire logic lo_fix = (acc_ff[3:0] > BCD_MAX) | flg_ff[FLG_AUX];
	wire logic [8:0] da1 = {1'b0, acc_ff} + {1'b0, (lo_fix ? BCD_LO_FIX : 8'h00)};
	// a kept carry is never cleared by the low step
	wire logic da_c1 = flg_ff[FLG_CARRY] | da1[8];
	wire logic hi_fix = da_c1 | (da1[7:4] > BCD_MAX);
	wire logic [8:0] da2 = {1'b0, da1[7:0]} + {1'b0, (hi_fix ? BCD_HI_FIX : 8'h00)};

	// compare flag update for a chosen width
	function automatic logic [4:0] cmp_flags(input ccb_size_type sz, input logic [4:0] f,
		input logic [8:0] r8, input logic [16:0] r16, input logic [32:0] r32,
		input logic b3, input logic o8, input logic o16, input logic o32);
		logic [4:0] g;
		g = f;
		g[FLG_AUX] = b3;
		case (sz)
			SZ_BYTE: begin
				g[FLG_CARRY] = r8[8];
				g[FLG_WRAP] = o8;
				g[FLG_NEG] = r8[7];
				g[FLG_ZERO] = (r8[7:0] == 8'h00);
			end
			SZ_WORD: begin
				g[FLG_CARRY] = r16[16];
				g[FLG_WRAP] = o16;
				g[FLG_NEG] = r16[15];
				g[FLG_ZERO] = (r16[15:0] == 16'h0000);
			end
			default: begin
				g[FLG_CARRY] = r32[32];
				g[FLG_WRAP] = o32;
				g[FLG_NEG] = r32[31];
				g[FLG_ZERO] = (r32[31:0] == 32'h0000_0000);
			end
		endcase
		return g;
	endfunction

	// ---- execute ----
	always_comb begin
		ccb_size_type sz;
		logic is_cmp;
		logic [3:0] cst;
		sz = SZ_BYTE;
		is_cmp = 1'b0;
		cst = 4'h0;
		nxt_acc = acc_ff;
		nxt_flg = flg_ff;
		nxt_res = '0;
		nxt_res.done = ins.valid;
		if (ins.valid) begin
			case (lop)
				OP_CLR_A: begin
					nxt_acc = 8'h00;
					nxt_flg[FLG_NEG] = 1'b0;
					nxt_flg[FLG_ZERO] = 1'b1;
					nxt_res.states = 4'h1;
				end
				OP_CPL_A: begin
					nxt_acc = ~acc_ff;
					nxt_flg[FLG_NEG] = ~acc_ff[7];
					nxt_flg[FLG_ZERO] = (acc_ff == 8'hFF);
					nxt_res.states = 4'h1;
				end
				OP_DADJ: begin
					nxt_acc = da2[7:0];
					// signed wrap untouched here
					nxt_flg[FLG_CARRY] = da_c1 | da2[8];
					nxt_flg[FLG_NEG] = da2[7];
					nxt_flg[FLG_ZERO] = (da2[7:0] == 8'h00);
					nxt_res.states = 4'h1;
				end
				OP_CLR_CY: begin
					nxt_flg[FLG_CARRY] = 1'b0;
					nxt_res.states = 4'h1;
				end
				OP_CPL_CY: begin
					nxt_flg[FLG_CARRY] = ~flg_ff[FLG_CARRY];
					nxt_res.states = 4'h1;
				end
				OP_CLR_B51: begin
					nxt_res.bit_we = 1'b1;
					nxt_res.bit_val = 1'b0;
					nxt_res.states = 4'h2 + port_bit_add;
				end
				OP_CPL_B51: begin
					nxt_res.bit_we = 1'b1;
					nxt_res.bit_val = ~opnd.bit_val;
					nxt_res.states = 4'h2 + port_bit_add;
				end
				default: begin
					if (!ext_ok) begin
						nxt_res.illegal = 1'b1;
					end else begin
						case (xop)
							OP_BITX: begin
								if (xsub[7:4] == SUB_CLR_BIT && !xsub[3]) begin
									nxt_res.bit_we = 1'b1;
									nxt_res.bit_val = 1'b0;
									nxt_res.states = 4'h3 + bin_add + port_bit_add;
								end else if (xsub[7:4] == SUB_CPL_BIT && !xsub[3]) begin
									nxt_res.bit_we = 1'b1;
									nxt_res.bit_val = ~opnd.bit_val;
									nxt_res.states = 4'h3 + bin_add + port_bit_add;
								end else begin
									nxt_res.illegal = 1'b1;
								end
							end
							OP_CMP_B: begin
								is_cmp = 1'b1;
								cst = 4'h1;
							end
							OP_CMP_W: begin
								is_cmp = 1'b1;
								sz = SZ_WORD;
								cst = 4'h2;
							end
							OP_CMP_D: begin
								is_cmp = 1'b1;
								sz = SZ_DWORD;
								cst = 4'h4;
							end
							OP_CMP_X: begin
								is_cmp = 1'b1;
								case (xsub[3:0])
									4'h0: cst = 4'h2;
									4'h1: cst = 4'h2 + port_dir_add;
									4'h3: cst = 4'h2;
									4'h9: cst = 4'h2;
									4'hB: cst = 4'h3;
									4'h4: begin
										sz = SZ_WORD;
										cst = 4'h3;
									end
									4'h5, 4'h7: begin
										sz = SZ_WORD;
										cst = 4'h3;
									end
									4'h8, 4'hC: begin
										sz = SZ_DWORD;
										cst = 4'h5;
									end
									default: begin
										is_cmp = 1'b0;
										nxt_res.illegal = 1'b1;
									end
								endcase
							end
							default: nxt_res.illegal = 1'b1;
						endcase
						if (is_cmp) begin
							// result discarded, operands stay as they are
							nxt_flg = cmp_flags(sz, flg_ff, d8, d16, d32, dnib[4], v8, v16, v32);
							nxt_res.states = cst + bin_add;
						end
					end
				end
			endcase
		end
	end

	// ---- state ----
	// an executing instruction outranks a same-cycle apb write to acc or flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_ff <= RST_ACC;
			flg_ff <= RST_FLAGS;
			res_ff <= '0;
		end else begin
			res_ff <= nxt_res;
			acc_ff <= (ins.valid || !wr_acc) ? nxt_acc : pwdata[7:0];
			flg_ff <= (ins.valid || !wr_flg) ? nxt_flg : pwdata[4:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_mode_ff <= 1'b0;
		end else if (wr_ctrl) begin
			src_mode_ff <= pwdata[0];
		end
	end

	// ready rises in the access phase; no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= setup_ph;
			pslverr_ff <= setup_ph & ~hit_any;
			prdata_ff <= setup_ph ? rd_mux : 32'h0000_0000;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign res = res_ff;
	assign acc = acc_ff;
	assign flags = flg_ff;
endmodule

// *** ccb_exec_asserts.sv ***
// Purpose: port checks for the clear/compare/complement/bcd unit
// Assumes: one clock; results land one edge after ins.valid
// Notes: opcode checks look at the first byte, legacy forms only
module ccb_exec_asserts
	import ccb_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire ccb_ins_type ins,
	input wire ccb_opnd_type opnd,
	input wire ccb_res_type res,
	input wire logic [7:0] acc,
	input wire logic [4:0] flags
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire da_go = ins.valid && ins.b0 == OP_DADJ;
	a_done_next: assert property (ins.valid |=> res.done)
		else $error("no done after valid");
	a_cpl_inverts: assert property (ins.valid && ins.b0 == OP_CPL_A |=> acc == ~$past(acc))
		else $error("acc not inverted");
	a_clr_zeroes: assert property (ins.valid && ins.b0 == OP_CLR_A |=> acc == 8'h00 && flags[FLG_ZERO])
		else $error("acc not cleared");
	a_da_wrap: assert property (da_go |=> $stable(flags[FLG_WRAP]))
		else $error("wrap flag moved");
	a_da_carry_kept: assert property (da_go && flags[FLG_CARRY] |=> flags[FLG_CARRY])
		else $error("carry cleared by adjust");
	a_da_no_fix: assert property (da_go && flags[1:0] == 2'h0 && acc[3:0] <= BCD_MAX
		&& acc[7:4] <= BCD_MAX |=> acc == $past(acc)) else $error("decimal acc altered");
	a_cy_toggles: assert property (ins.valid && ins.b0 == OP_CPL_CY |=> $changed(flags[FLG_CARRY]))
		else $error("carry not complemented");
	a_port_states: assert property (ins.valid && ins.b0 == OP_CPL_B51 && opnd.on_port
		|=> res.states == 4'h4) else $error("port bit states wrong");
	a_illegal_hold: assert property (res.illegal |-> $stable(acc) && $stable(flags))
		else $error("illegal form changed state");
	c_adjust: cover property (da_go);
	c_illegal: cover property (res.illegal);
	c_apb_err: cover property (pready && pslverr);
endmodule

bind ccb_exec ccb_exec_asserts u_ccb_exec_asserts (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .ins, .opnd, .res, .acc, .flags);

// *** ccb_fetch_model.sv ***
// Purpose: fetch stage model feeding instruction and operand bytes
// Assumes: one instruction per call, valid for one cycle
// Notes: idle bytes are inverted so a stale opcode never looks fresh
module ccb_fetch_model
	import ccb_pkg::*;
(
	input wire logic pclk,
	output ccb_ins_type ins,
	output ccb_opnd_type opnd
);
	initial begin
		ins = '0;
		opnd = '0;
	end
	task automatic issue(input logic [7:0] b0, b1, b2, input logic [31:0] d, s,
		input logic bv, p);
		@(posedge pclk);
		ins <= '{1'h1, b0, b1, b2};
		opnd <= '{d, s, bv, p};
		@(posedge pclk);
		ins <= '{1'h0, ~b0, ~b1, ~b2};
		opnd <= '{~d, ~s, ~bv, ~p};
	endtask
endmodule

// *** ccb_pkg.sv ***
// Purpose: shared constants and carriers for the clear/compare/complement/bcd unit
// Assumes: 32-bit apb, single core clock
// Notes: offsets are byte addresses
package ccb_pkg;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ACC = 8'h04;
	localparam logic [7:0] OFS_FLAGS = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam int FLG_CARRY = 0;
	localparam int FLG_AUX = 1;
	localparam int FLG_WRAP = 2;
	localparam int FLG_NEG = 3;
	localparam int FLG_ZERO = 4;
	localparam logic [4:0] RST_FLAGS = 5'h00;
	localparam logic [7:0] RST_ACC = 8'h00;
	localparam logic [7:0] ESC_BYTE = 8'hA5;
	// legacy one-byte opcodes
	localparam logic [7:0] OP_CLR_A = 8'hE4;
	localparam logic [7:0] OP_CLR_CY = 8'hC3;
	localparam logic [7:0] OP_CLR_B51 = 8'hC2;
	localparam logic [7:0] OP_CPL_A = 8'hF4;
	localparam logic [7:0] OP_CPL_CY = 8'hB3;
	localparam logic [7:0] OP_CPL_B51 = 8'hB2;
	localparam logic [7:0] OP_DADJ = 8'hD4;
	// extended opcodes
	localparam logic [7:0] OP_BITX = 8'hA9;
	localparam logic [3:0] SUB_CLR_BIT = 4'hC;
	localparam logic [3:0] SUB_CPL_BIT = 4'hB;
	localparam logic [7:0] OP_CMP_B = 8'hBC;
	localparam logic [7:0] OP_CMP_W = 8'hBD;
	localparam logic [7:0] OP_CMP_D = 8'hBF;
	localparam logic [7:0] OP_CMP_X = 8'hBE;
	localparam logic [7:0] BCD_LO_FIX = 8'h06;
	localparam logic [7:0] BCD_HI_FIX = 8'h60;
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [3:0] PORT_BIT_EXTRA = 4'h2;
	localparam logic [3:0] PORT_DIR_EXTRA = 4'h1;
	localparam logic [3:0] BIN_EXTRA = 4'h1;
	typedef enum logic [1:0] {
		SZ_BYTE = 2'b00,
		SZ_WORD = 2'b01,
		SZ_DWORD = 2'b11
	} ccb_size_type;
	typedef struct packed {
		logic valid;
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] b2;
	} ccb_ins_type;
	typedef struct packed {
		logic [31:0] dst;
		logic [31:0] src;
		logic bit_val;
		logic on_port;
	} ccb_opnd_type;
	typedef struct packed {
		logic done;
		logic illegal;
		logic bit_we;
		logic bit_val;
		logic [3:0] states;
	} ccb_res_type;
endpackage

// *** tb_top.sv ***
// Purpose: self-checking bench for ccb_exec
// Assumes: apb answers in the access cycle; results one edge after valid
// Notes: only the acc test masks state checks to the flag bits each instruction owns; the adjust and compare tests check all five flags, the bit test none
module tb_top
	import ccb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr, acc;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0] flags;
	ccb_ins_type ins;
	ccb_opnd_type opnd;
	ccb_res_type res;
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	wire [15:0] st = {3'h0, flags, acc};
	logic [31:0] tv [6] = '{32'hBE040524, 32'hC9040529, 32'h12050572, 32'h11060617,
		32'h9A041500, 32'h45040445};
	ccb_exec u_ccb_exec (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .ins, .opnd, .res, .acc, .flags);
	ccb_fetch_model u_ccb_fetch (.pclk, .ins, .opnd);
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	// cut a hang short; the whole run needs about 120 cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic chk(input logic [15:0] s, e);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// no local limit: a slave that never answers runs into the bench timeout
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic run(input logic [7:0] b0, b1, b2, input logic [31:0] d, s, input logic p,
		input logic bv = 1'h1);
		u_ccb_fetch.issue(b0, b1, b2, d, s, bv, p);
		#1;
	endtask
	task automatic t_acc();
		apb(1'h1, OFS_ACC, 32'h5C);
		apb(1'h0, OFS_ACC, 32'h0);
		chk({rd[14:0], er}, 16'h00B8);
		run(OP_CPL_A, 8'h0, 8'h0, 32'h0, 32'h0, 1'h0);
		chk(st & 16'h18FF, 16'h08A3);
		run(OP_CLR_A, 8'h0, 8'h0, 32'h0, 32'h0, 1'h0);
		chk(st & 16'h18FF, 16'h1000);
		chk({11'h0, res.done, res.states}, 16'h0011);
		apb(1'h0, 8'h10, 32'h0);
		chk({rd[14:0], er}, 16'h0001);
		$display("test acc done");
	endtask
	task automatic t_da();
		foreach (tv[i]) begin
			apb(1'h1, OFS_ACC, {24'h0, tv[i][31:24]});
			apb(1'h1, OFS_FLAGS, {24'h0, tv[i][23:16]});
			run(OP_DADJ, 8'h0, 8'h0, 32'h0, 32'h0, 1'h0);
			chk(st & 16'h1FFF, tv[i][15:0]);
			chk({11'h0, res.done, res.states}, 16'h0011);
		end
		$display("test adjust done");
	endtask
	task automatic t_bit();
		run(OP_CLR_B51, 8'h90, 8'h0, 32'h0, 32'h0, 1'h1);
		chk({10'h0, res.bit_we, res.bit_val, res.states}, 16'h0024);
		run(OP_CLR_B51, 8'h20, 8'h0, 32'h0, 32'h0, 1'h0);
		chk({10'h0, res.bit_we, res.bit_val, res.states}, 16'h0022);
		run(OP_CPL_B51, 8'h91, 8'h0, 32'h0, 32'h0, 1'h1, 1'h0);
		chk({10'h0, res.bit_we, res.bit_val, res.states}, 16'h0034);
		run(ESC_BYTE, OP_BITX, 8'hC0, 32'h0, 32'h0, 1'h1);
		chk({10'h0, res.bit_we, res.bit_val, res.states}, 16'h0026);
		run(ESC_BYTE, OP_BITX, 8'hB0, 32'h0, 32'h0, 1'h1, 1'h0);
		chk({10'h0, res.bit_we, res.bit_val, res.states}, 16'h0036);
		$display("test bit done");
	endtask
	task automatic t_cmp();
		apb(1'h1, OFS_ACC, 32'h33);
		apb(1'h1, OFS_FLAGS, 32'h0);
		run(ESC_BYTE, OP_CMP_B, 8'h10, 32'hC9, 32'h54, 1'h0);
		chk(st & 16'h1FFF, 16'h0433);
		chk({11'h0, res.done, res.states}, 16'h0012);
		run(ESC_BYTE, OP_CMP_W, 8'h10, 32'h0, 32'h1, 1'h0);
		chk(st & 16'h1FFF, 16'h0B33);
		chk({11'h0, res.done, res.states}, 16'h0013);
		run(ESC_BYTE, OP_CMP_D, 8'h10, 32'h80000000, 32'h1, 1'h0);
		chk(st & 16'h1FFF, 16'h0633);
		chk({11'h0, res.done, res.states}, 16'h0015);
		run(OP_CMP_B, 8'h10, 8'h0, 32'h1, 32'h2, 1'h0);
		chk({15'h0, res.illegal}, 16'h0001);
		apb(1'h1, OFS_CTRL, 32'h1);
		run(OP_CMP_B, 8'h10, 8'h0, 32'h54, 32'hC9, 1'h0);
		chk(st & 16'h1FFF, 16'h0F33);
		chk({11'h0, res.done, res.states}, 16'h0011);
		run(ESC_BYTE, OP_CMP_B, 8'h10, 32'h1, 32'h2, 1'h0);
		chk({15'h0, res.illegal}, 16'h0001);
		run(OP_CLR_CY, 8'h0, 8'h0, 32'h0, 32'h0, 1'h0);
		chk(st & 16'h1FFF, 16'h0E33);
		run(OP_CPL_CY, 8'h0, 8'h0, 32'h0, 32'h0, 1'h0);
		chk(st & 16'h1FFF, 16'h0F33);
		run(OP_CMP_X, 8'h01, 8'h0, 32'h5, 32'h5, 1'h1);
		chk(st & 16'h1FFF, 16'h1033);
		chk({11'h0, res.done, res.states}, 16'h0013);
		$display("test compare done");
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		t_acc();
		t_da();
		t_bit();
		t_cmp();
		end_of_test();
	end
endmodule
